// ===== verilog/itfc_ctrl.sv
/*
 Global trap control, vector-table/edge control and request-flag registers
 of an interrupt controller, with a 16-bit register port.
 Assumes peripheral requests and trap events are synchronous one-cycle pulses
 on clk, and the external pins are asynchronous.
*/
`timescale 1ns/1ps
`default_nettype none
`include "itfc_cfg.svh"

module itfc_ctrl
    import itfc_pkg::*;
(
    input  wire  logic                     clk,
    input  wire  logic                     reset,
    input  wire  logic                     clk_en,
    input  wire  logic [`ITFC_ADDR_W-1:0]  reg_addr,
    input  wire  logic [15:0]              reg_wdata,
    input  wire  logic                     reg_wr,
    input  wire  logic                     reg_rd,
    output var   logic [15:0]              reg_rdata,
    input  wire  itfc_periph_req_s         periph_req,
    input  wire  itfc_trap_evt_s           trap_evt,
    input  wire  logic                     timed_disable_in,
    input  wire  logic [2:0]               ext_pin,
    output var   logic                     alternate_table_select,
    output var   logic                     nesting_disable,
    output var   logic [2:0]               cpu_priority_level,
    output var   logic                     acc_a_overflow_trap_enable,
    output var   logic                     acc_b_overflow_trap_enable,
    output var   logic                     catastrophic_trap_enable,
    output var   logic                     request_pending
);

    // Set-wins-over-clear update used by every hardware-set register
    function automatic itfc_word_t merge_reg(input itfc_word_t cur, input itfc_word_t wdat,
                                             input logic wr, input itfc_word_t wmask,
                                             input itfc_word_t setv, input itfc_word_t impl);
        itfc_word_t r;
        r = wr ? ((cur & ~wmask) | (wdat & wmask)) : cur;
        merge_reg = (r | setv) & impl;
    endfunction

    itfc_word_t  trap_q,   trap_d;
    itfc_word_t  vec_q,    vec_d;
    itfc_word_t  first_q,  first_d;
    itfc_word_t  second_q, second_d;
    itfc_word_t  fourth_q, fourth_d;
    itfc_word_t  fifth_q,  fifth_d;
    logic [2:0]  prio_q;
    logic [2:0]  prio_d;
    logic [2:0]  pin_meta_q;
    logic [2:0]  pin_sync_q;
    logic [2:0]  pin_prev_q;
    logic        timed_disable_active_meta_q;
    logic        timed_disable_active_sync_q;
    logic [15:0] rdata_q;
    logic        pend_q;

    wire        wr_trap   = reg_wr && (reg_addr == `ITFC_OFF_TRAP_CTRL);
    wire        wr_vec    = reg_wr && (reg_addr == `ITFC_OFF_VEC_EDGE);
    wire        wr_first  = reg_wr && (reg_addr == `ITFC_OFF_FLAGS_FIRST);
    wire        wr_second = reg_wr && (reg_addr == `ITFC_OFF_FLAGS_SECOND);
    wire        wr_fourth = reg_wr && (reg_addr == `ITFC_OFF_FLAGS_FOURTH);
    wire        wr_fifth  = reg_wr && (reg_addr == `ITFC_OFF_FLAGS_FIFTH);
    wire        wr_prio   = reg_wr && (reg_addr == `ITFC_OFF_CPU_PRIO);

    // Edge detect on synchronised pins, polarity picks the edge
    wire [2:0]  pol      = vec_q[2:0];
    wire [2:0]  rise     = pin_sync_q & ~pin_prev_q;
    wire [2:0]  fall     = ~pin_sync_q & pin_prev_q;
    wire [2:0]  pin_evt  = (pol & fall) | (~pol & rise);

    // Overflow traps only flag when their enables allow them
    wire        ova_set  = trap_evt.acc_a_overflow && trap_q[`ITFC_TRAP_ACC_A_OVERFLOW_TRAP_ENABLE_BIT];
    wire        ovb_set  = trap_evt.acc_b_overflow && trap_q[`ITFC_TRAP_ACC_B_OVERFLOW_TRAP_ENABLE_BIT];
    wire        cova_set = trap_evt.acc_a_catastrophic && trap_q[`ITFC_TRAP_CATASTROPHIC_TRAP_ENABLE_BIT];
    wire        covb_set = trap_evt.acc_b_catastrophic && trap_q[`ITFC_TRAP_CATASTROPHIC_TRAP_ENABLE_BIT];

    wire itfc_word_t trap_set = {1'b0, ova_set, ovb_set, cova_set, covb_set, 3'b000,
                                 trap_evt.shift_error, trap_evt.arith_error, 1'b0,
                                 trap_evt.math_trap, trap_evt.address_trap,
                                 trap_evt.stack_trap, trap_evt.oscillator_fail, 1'b0};

    wire itfc_word_t first_set = {2'b00, periph_req.conversion_done, periph_req.serial_transmit,
                                  periph_req.serial_receive, periph_req.spi_event,
                                  periph_req.spi_fault, periph_req.timer_third,
                                  periph_req.timer_second, periph_req.compare_ch2,
                                  periph_req.capture_ch2, 1'b0, periph_req.timer_first,
                                  periph_req.compare_ch1, periph_req.capture_ch1,
                                  pin_evt[0]};

    wire itfc_word_t second_set = {2'b00, pin_evt[2], 8'h00, pin_evt[1],
                                   periph_req.change_notify, periph_req.comparator_one,
                                   periph_req.i2c_master_event, periph_req.i2c_slave_event};

    wire itfc_word_t fourth_set = {6'h00, periph_req.pwm_special_match, 9'h000};
    wire itfc_word_t fifth_set  = {14'h0000, periph_req.serial_error, 1'b0};

    wire itfc_word_t vec_read   = (vec_q & `ITFC_MASK_VEC_WR)
                                  | (16'(timed_disable_active_sync_q) << `ITFC_VEC_TIMED_DISABLE_ACTIVE_BIT);

    assign trap_d   = merge_reg(trap_q, reg_wdata, wr_trap, 16'hFFFF, trap_set, `ITFC_MASK_TRAP);
    assign vec_d    = merge_reg(vec_q, reg_wdata, wr_vec, 16'hFFFF, 16'h0000, `ITFC_MASK_VEC_WR);
    assign first_d  = merge_reg(first_q, reg_wdata, wr_first, 16'hFFFF, first_set, `ITFC_MASK_FIRST);
    assign second_d = merge_reg(second_q, reg_wdata, wr_second, 16'hFFFF, second_set, `ITFC_MASK_SECOND);
    assign fourth_d = merge_reg(fourth_q, reg_wdata, wr_fourth, 16'hFFFF, fourth_set, `ITFC_MASK_FOURTH);
    assign fifth_d  = merge_reg(fifth_q, reg_wdata, wr_fifth, 16'hFFFF, fifth_set, `ITFC_MASK_FIFTH);
    assign prio_d   = (wr_prio && !trap_q[`ITFC_TRAP_NEST_BIT]) ? reg_wdata[2:0] : prio_q;

    wire [15:0] rd_mux = (reg_addr == `ITFC_OFF_TRAP_CTRL)    ? trap_q   :
                         (reg_addr == `ITFC_OFF_VEC_EDGE)     ? vec_read :
                         (reg_addr == `ITFC_OFF_FLAGS_FIRST)  ? first_q  :
                         (reg_addr == `ITFC_OFF_FLAGS_SECOND) ? second_q :
                         (reg_addr == `ITFC_OFF_FLAGS_FOURTH) ? fourth_q :
                         (reg_addr == `ITFC_OFF_FLAGS_FIFTH)  ? fifth_q  :
                         (reg_addr == `ITFC_OFF_CPU_PRIO)     ? {13'h0, prio_q} :
                         16'h0000;

    wire        pend_d = |{first_d, second_d, fourth_d, fifth_d};

    // Pins and the disable-status level arrive from outside this clock
    always_ff @(posedge clk) begin
        if (reset) begin
            pin_meta_q  <= 3'h0;
            pin_sync_q  <= 3'h0;
            pin_prev_q  <= 3'h0;
            timed_disable_active_meta_q <= 1'b0;
            timed_disable_active_sync_q <= 1'b0;
        end else if (clk_en) begin
            pin_meta_q  <= ext_pin;
            pin_sync_q  <= pin_meta_q;
            pin_prev_q  <= pin_sync_q;
            timed_disable_active_meta_q <= timed_disable_in;
            timed_disable_active_sync_q <= timed_disable_active_meta_q;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            trap_q   <= `ITFC_RESET_VALUE;
            vec_q    <= `ITFC_RESET_VALUE;
            first_q  <= `ITFC_RESET_VALUE;
            second_q <= `ITFC_RESET_VALUE;
            fourth_q <= `ITFC_RESET_VALUE;
            fifth_q  <= `ITFC_RESET_VALUE;
            prio_q   <= 3'h0;
        end else if (clk_en) begin
            trap_q   <= trap_d;
            vec_q    <= vec_d;
            first_q  <= first_d;
            second_q <= second_d;
            fourth_q <= fourth_d;
            fifth_q  <= fifth_d;
            prio_q   <= prio_d;
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_q <= 16'h0000;
            pend_q  <= 1'b0;
        end else if (clk_en) begin
            rdata_q <= reg_rd ? rd_mux : 16'h0000;
            pend_q  <= pend_d;
        end
    end

    // Control outputs are copies of register bits, so they come from flops
    assign reg_rdata                  = rdata_q;
    assign alternate_table_select     = vec_q[`ITFC_VEC_ALT_BIT];
    assign nesting_disable            = trap_q[`ITFC_TRAP_NEST_BIT];
    assign cpu_priority_level         = prio_q;
    assign acc_a_overflow_trap_enable = trap_q[`ITFC_TRAP_ACC_A_OVERFLOW_TRAP_ENABLE_BIT];
    assign acc_b_overflow_trap_enable = trap_q[`ITFC_TRAP_ACC_B_OVERFLOW_TRAP_ENABLE_BIT];
    assign catastrophic_trap_enable   = trap_q[`ITFC_TRAP_CATASTROPHIC_TRAP_ENABLE_BIT];
    assign request_pending            = pend_q;

    sticky_first_a: assert property (@(posedge clk) disable iff (reset)
        (clk_en && first_q[3] && !(wr_first && !reg_wdata[3])) |=> first_q[3])
        else $error("first flag dropped without software clear");

    set_wins_a: assert property (@(posedge clk) disable iff (reset)
        (clk_en && periph_req.timer_first && wr_first && !reg_wdata[3]) |=> first_q[3])
        else $error("hardware set lost to same-cycle clear");

    prio_lock_a: assert property (@(posedge clk) disable iff (reset)
        (clk_en && trap_q[15] && wr_prio) |=> $stable(prio_q))
        else $error("priority level changed while nesting disabled");

    unimpl_zero_a: assert property (@(posedge clk) disable iff (reset)
        ((trap_q & ~16'hFFDE) == 16'h0000) && ((second_q & 16'hDFE0) == 16'h0000)
        && ((fourth_q & 16'hFDFF) == 16'h0000) && ((fifth_q & 16'hFFFD) == 16'h0000))
        else $error("unimplemented bit set");

    ova_gate_a: assert property (@(posedge clk) disable iff (reset)
        (clk_en && trap_evt.acc_a_overflow && trap_q[10]) |=> trap_q[14])
        else $error("accumulator A overflow not flagged");

    cov_gate_a: assert property (@(posedge clk) disable iff (reset)
        (clk_en && !trap_q[8] && !trap_q[12] && !wr_trap) |=> !trap_q[12])
        else $error("catastrophic flag set while disabled");

    pin_edge_a: assert property (@(posedge clk) disable iff (reset)
        (clk_en && !vec_q[0] && !pin_prev_q[0] && pin_sync_q[0]) |=> first_q[0])
        else $error("rising edge on pin 0 not flagged");

    stack_flag_a: assert property (@(posedge clk) disable iff (reset)
        (clk_en && trap_evt.stack_trap) |=> trap_q[2])
        else $error("stack trap not flagged");

    read_data_a: assert property (@(posedge clk) disable iff (reset)
        (clk_en && reg_rd && reg_addr == 3'h2) |=> (reg_rdata == $past(first_q)))
        else $error("read data mismatch");

    // Per-rule checks on the trap, flag and control paths
    ovb_gate_a: assert property (@(posedge clk) disable iff (reset)
        (clk_en && trap_evt.acc_b_overflow && trap_q[9]) |=> trap_q[13])
        else $error("accumulator B overflow not flagged");

    ova_block_a: assert property (@(posedge clk) disable iff (reset)
        (clk_en && !trap_q[10] && !trap_q[14] && !wr_trap) |=> !trap_q[14])
        else $error("accumulator A overflow flagged while disabled");

    ovb_block_a: assert property (@(posedge clk) disable iff (reset)
        (clk_en && !trap_q[9] && !trap_q[13] && !wr_trap) |=> !trap_q[13])
        else $error("accumulator B overflow flagged while disabled");

    covb_block_a: assert property (@(posedge clk) disable iff (reset)
        (clk_en && !trap_q[8] && !trap_q[11] && !wr_trap) |=> !trap_q[11])
        else $error("catastrophic B flag set while disabled");

    cova_gate_a: assert property (@(posedge clk) disable iff (reset)
        (clk_en && trap_evt.acc_a_catastrophic && trap_q[8]) |=> trap_q[12])
        else $error("catastrophic A overflow not flagged");

    covb_gate_a: assert property (@(posedge clk) disable iff (reset)
        (clk_en && trap_evt.acc_b_catastrophic && trap_q[8]) |=> trap_q[11])
        else $error("catastrophic B overflow not flagged");

    cova_own_a: assert property (@(posedge clk) disable iff (reset)
        (clk_en && trap_evt.acc_b_catastrophic && !trap_evt.acc_a_catastrophic
         && !trap_q[12] && !wr_trap) |=> !trap_q[12])
        else $error("catastrophic A flag set by accumulator B");

    shift_flag_a: assert property (@(posedge clk) disable iff (reset)
        (clk_en && trap_evt.shift_error) |=> trap_q[7])
        else $error("shift error not recorded");

    arith_flag_a: assert property (@(posedge clk) disable iff (reset)
        (clk_en && trap_evt.arith_error) |=> trap_q[6])
        else $error("arithmetic error not recorded");

    osc_flag_a: assert property (@(posedge clk) disable iff (reset)
        (clk_en && trap_evt.oscillator_fail) |=> trap_q[1])
        else $error("oscillator failure not flagged");

    stack_quiet_a: assert property (@(posedge clk) disable iff (reset)
        (clk_en && !trap_evt.stack_trap && !trap_q[2] && !wr_trap) |=> !trap_q[2])
        else $error("stack flag set without a trap");

    osc_quiet_a: assert property (@(posedge clk) disable iff (reset)
        (clk_en && !trap_evt.oscillator_fail && !trap_q[1] && !wr_trap) |=> !trap_q[1])
        else $error("oscillator flag set without a trap");

    unimpl_first_a: assert property (@(posedge clk) disable iff (reset)
        ((first_q & 16'hC010) == 16'h0000) && ((vec_q & 16'h7FF8) == 16'h0000))
        else $error("unimplemented flag or control bit set");

    unmapped_read_a: assert property (@(posedge clk) disable iff (reset)
        (clk_en && reg_rd && reg_addr == 3'h7) |=> (reg_rdata == 16'h0000))
        else $error("unmapped index read nonzero");

    alt_select_a: assert property (@(posedge clk) disable iff (reset)
        (clk_en && wr_vec && reg_wdata[15]) |=> alternate_table_select)
        else $error("alternate table not selected");

    alt_clear_a: assert property (@(posedge clk) disable iff (reset)
        (clk_en && wr_vec && !reg_wdata[15]) |=> !alternate_table_select)
        else $error("default table not selected");

    timed_disable_active_read_a: assert property (@(posedge clk) disable iff (reset)
        (clk_en && reg_rd && reg_addr == 3'h1) |=> (reg_rdata[14] == $past(timed_disable_active_sync_q)))
        else $error("timed disable status read wrong");

    pin_fall_a: assert property (@(posedge clk) disable iff (reset)
        (clk_en && vec_q[0] && pin_prev_q[0] && !pin_sync_q[0]) |=> first_q[0])
        else $error("falling edge on pin 0 not flagged");

    pin1_edge_a: assert property (@(posedge clk) disable iff (reset)
        (clk_en && pin_evt[1]) |=> second_q[4])
        else $error("pin 1 edge not flagged");

    pin2_edge_a: assert property (@(posedge clk) disable iff (reset)
        (clk_en && pin_evt[2]) |=> second_q[13])
        else $error("pin 2 edge not flagged");

    conv_flag_a: assert property (@(posedge clk) disable iff (reset)
        (clk_en && periph_req.conversion_done) |=> first_q[13])
        else $error("conversion flag not set");

    timer3_flag_a: assert property (@(posedge clk) disable iff (reset)
        (clk_en && periph_req.timer_third) |=> first_q[8])
        else $error("third timer flag not set");

    capture2_flag_a: assert property (@(posedge clk) disable iff (reset)
        (clk_en && periph_req.capture_ch2) |=> first_q[5])
        else $error("capture 2 flag not set");

    notify_flag_a: assert property (@(posedge clk) disable iff (reset)
        (clk_en && periph_req.change_notify) |=> second_q[3])
        else $error("change notify flag not set");

    pwm_match_a: assert property (@(posedge clk) disable iff (reset)
        (clk_en && periph_req.pwm_special_match) |=> fourth_q[9])
        else $error("pwm match flag not set");

    serial_err_a: assert property (@(posedge clk) disable iff (reset)
        (clk_en && periph_req.serial_error) |=> fifth_q[1])
        else $error("serial error flag not set");

    sticky_second_a: assert property (@(posedge clk) disable iff (reset)
        (clk_en && second_q[3] && !wr_second) |=> second_q[3])
        else $error("second flag dropped without software write");

    fourth_write_a: assert property (@(posedge clk) disable iff (reset)
        (clk_en && wr_fourth && reg_wdata[9]) |=> fourth_q[9])
        else $error("flag not writable");

    nest_bit_a: assert property (@(posedge clk) disable iff (reset)
        (clk_en && wr_trap && reg_wdata[15]) |=> nesting_disable)
        else $error("nesting disable not held");

    prio_write_a: assert property (@(posedge clk) disable iff (reset)
        (clk_en && !trap_q[15] && wr_prio && reg_wdata[2:0] == 3'h5) |=> (prio_q == 3'h5))
        else $error("priority write lost while nesting enabled");

    // Gated cycles must not move any flag, so a request pulse in a gated cycle is lost
    frozen_state_a: assert property (@(posedge clk) disable iff (reset)
        (!clk_en) |=> ($stable(first_q) && $stable(trap_q) && $stable(second_q)))
        else $error("state moved while clock enable low");

    pending_set_a: assert property (@(posedge clk) disable iff (reset)
        (clk_en && first_d[3]) |=> request_pending)
        else $error("pending not raised for a set flag");

endmodule // itfc_ctrl
`default_nettype wire

// ===== inc/itfc_cfg.svh
/*
 Register offsets, field positions, reset values and implemented-bit masks
 for the trap, vector-table and request-flag control block.
 Assumes a 16-bit register port; offsets are word indices on that port.
*/
`ifndef ITFC_CFG_SVH
`define ITFC_CFG_SVH

`define ITFC_ADDR_W            3
`define ITFC_OFF_TRAP_CTRL     3'h0
`define ITFC_OFF_VEC_EDGE      3'h1
`define ITFC_OFF_FLAGS_FIRST   3'h2
`define ITFC_OFF_FLAGS_SECOND  3'h3
`define ITFC_OFF_FLAGS_FOURTH  3'h4
`define ITFC_OFF_FLAGS_FIFTH   3'h5
`define ITFC_OFF_CPU_PRIO      3'h6

`define ITFC_RESET_VALUE       16'h0000

`define ITFC_TRAP_NEST_BIT     15
`define ITFC_TRAP_OVA_BIT      14
`define ITFC_TRAP_OVB_BIT      13
`define ITFC_TRAP_COVA_BIT     12
`define ITFC_TRAP_COVB_BIT     11
`define ITFC_TRAP_ACC_A_OVERFLOW_TRAP_ENABLE_BIT    10
`define ITFC_TRAP_ACC_B_OVERFLOW_TRAP_ENABLE_BIT    9
`define ITFC_TRAP_CATASTROPHIC_TRAP_ENABLE_BIT    8
`define ITFC_TRAP_SHIFT_BIT    7
`define ITFC_TRAP_ARITH_BIT    6
`define ITFC_TRAP_MATH_BIT     4
`define ITFC_TRAP_ADDR_BIT     3
`define ITFC_TRAP_STACK_BIT    2
`define ITFC_TRAP_OSC_BIT      1

`define ITFC_VEC_ALT_BIT       15
`define ITFC_VEC_TIMED_DISABLE_ACTIVE_BIT      14

`define ITFC_MASK_TRAP         16'hFFDE
`define ITFC_MASK_VEC_WR       16'h8007
`define ITFC_MASK_FIRST        16'h3FEF
`define ITFC_MASK_SECOND       16'h201F
`define ITFC_MASK_FOURTH       16'h0200
`define ITFC_MASK_FIFTH        16'h0002

`endif

// ===== inc/itfc_pkg.sv
/*
 Types shared by the trap and request-flag control block.
 Assumes itfc_cfg.svh supplies the numeric constants.
*/
package itfc_pkg;

    typedef logic [15:0] itfc_word_t;

    // Request sources into the first, second, fourth and fifth flag registers
    typedef struct packed {
        logic conversion_done;
        logic serial_transmit;
        logic serial_receive;
        logic spi_event;
        logic spi_fault;
        logic timer_third;
        logic timer_second;
        logic compare_ch2;
        logic capture_ch2;
        logic timer_first;
        logic compare_ch1;
        logic capture_ch1;
        logic change_notify;
        logic comparator_one;
        logic i2c_master_event;
        logic i2c_slave_event;
        logic pwm_special_match;
        logic serial_error;
    } itfc_periph_req_s;

    // Trap causes reported by the core, one-cycle pulses
    typedef struct packed {
        logic acc_a_overflow;
        logic acc_b_overflow;
        logic acc_a_catastrophic;
        logic acc_b_catastrophic;
        logic shift_error;
        logic arith_error;
        logic math_trap;
        logic address_trap;
        logic stack_trap;
        logic oscillator_fail;
    } itfc_trap_evt_s;

endpackage

// ===== testbench/itfc_source_model.sv
/*
 Far-side model: peripheral request pulses, core trap pulses, external pin
 and timed-disable levels, each launched one clock edge after its command.
 Assumes the bench changes its commands just after a rising clk edge.
*/
`timescale 1ns/1ps
`default_nettype none
module itfc_source_model
    import itfc_pkg::*;
(
    input  wire logic             clk,
    input  wire logic [17:0]      fire_req,
    input  wire logic [9:0]       fire_trap,
    input  wire logic [2:0]       pin_lvl,
    input  wire logic             hold_lvl,
    output var  itfc_periph_req_s periph_req,
    output var  itfc_trap_evt_s   trap_evt,
    output var  logic [2:0]       ext_pin,
    output var  logic             timed_disable_in
);
    // Registered like a real source, so a request never lands on the command edge
    always @(posedge clk) begin
        periph_req <= fire_req;
        trap_evt <= fire_trap;
        ext_pin <= pin_lvl;
        timed_disable_in <= hold_lvl;
    end
endmodule // itfc_source_model
`default_nettype wire

// ===== testbench/itfc_ctrl_bench.sv
/*
 Self-checking bench for the trap and request-flag control block.
 Assumes itfc_cfg.svh and itfc_pkg are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "itfc_cfg.svh"
module itfc_ctrl_bench
    import itfc_pkg::*;
;
    logic clk = 1'b0, reset = 1'b1, clk_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, hold_lvl = 1'b0;
    logic [2:0]  reg_addr = 3'h0, pin_lvl = 3'h0, prio, ext_pin;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, m [0:7], wmask [0:7], keep;
    logic [17:0] fire_req = 18'h00000;
    logic [9:0]  fire_trap = 10'h000;
    logic [31:0] seed = 32'h7DE1C87B, r;
    logic        alt_sel, nest, ena, enb, cov_en, pend, dis_in;
    itfc_periph_req_s periph_req;
    itfc_trap_evt_s   trap_evt;
    int errors = 0, total_checks = 0, tbit [0:9];
    logic [7:0] loc [0:17], ploc [0:2];

    always #5 clk = ~clk;

    itfc_source_model itfc_source_model_inst (.clk(clk), .fire_req(fire_req), .fire_trap(fire_trap),
        .pin_lvl(pin_lvl), .hold_lvl(hold_lvl), .periph_req(periph_req), .trap_evt(trap_evt),
        .ext_pin(ext_pin), .timed_disable_in(dis_in));
    itfc_ctrl itfc_ctrl_inst (.clk(clk), .reset(reset), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .periph_req(periph_req), .trap_evt(trap_evt), .timed_disable_in(dis_in), .ext_pin(ext_pin),
        .alternate_table_select(alt_sel), .nesting_disable(nest), .cpu_priority_level(prio),
        .acc_a_overflow_trap_enable(ena), .acc_b_overflow_trap_enable(enb),
        .catastrophic_trap_enable(cov_en), .request_pending(pend));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    // Model tracks the priority lock, so the nesting bit is read before it changes
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        if (a == 3'h6) begin
            if (!m[0][15]) m[6] = d & 16'h0007;
        end else if (a != 3'h7) begin
            m[a] = (d & wmask[a]) | ((a == 3'h1) ? (m[1] & 16'h4000) : 16'h0000);
        end
    endtask

    task automatic rchk(input logic [2:0] a);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        chk("reg_rdata", m[a], reg_rdata);
    endtask

    task automatic fire(input logic [17:0] q, input logic [9:0] t);
        logic gate;
        @(posedge clk);
        fire_req <= q;
        fire_trap <= t;
        @(posedge clk);
        fire_req <= 18'h00000;
        fire_trap <= 10'h000;
        for (int i = 0; i < 18; i++) if (q[i]) m[loc[i][6:4]][loc[i][3:0]] = 1'b1;
        for (int i = 0; i < 10; i++) begin
            gate = (i < 8 && m[0][8]) || i < 6 || (i == 9 && m[0][10]) || (i == 8 && m[0][9]);
            if (t[i] && gate) m[0][tbit[i]] = 1'b1;
        end
    endtask

    task automatic outs();
        chk("outputs", {9'h000, m[1][15], m[0][15], m[0][10], m[0][9], m[0][8], m[6][2:0]},
            {9'h000, alt_sel, nest, ena, enb, cov_en, prio});
    endtask

    task automatic clr();
        for (int a = 2; a < 6; a++) wr(3'(a), 16'h0000);
    endtask

    task automatic final_report();
        if (errors == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        final_report();
    end

    initial begin
        wmask = '{16'hFFDE, 16'h8007, 16'h3FEF, 16'h201F, 16'h0200, 16'h0002, 16'h0007, 16'h0000};
        m = '{default: 16'h0000};
        tbit = '{1, 2, 3, 4, 6, 7, 11, 12, 13, 14};
        loc = '{8'h51, 8'h49, 8'h30, 8'h31, 8'h32, 8'h33, 8'h21, 8'h22, 8'h23, 8'h25, 8'h26, 8'h27,
                8'h28, 8'h29, 8'h2A, 8'h2B, 8'h2C, 8'h2D};
        ploc = '{8'h20, 8'h34, 8'h3D};
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        for (int a = 0; a < 8; a++) rchk(3'(a));
        wr(3'h6, 16'h0005);
        rchk(3'h6);
        outs();
        for (int a = 0; a < 6; a++) begin
            wr(3'(a), 16'hFFFF);
            rchk(3'(a));
        end
        wr(3'h7, 16'hFFFF);
        rchk(3'h7);
        outs();
        wr(3'h6, 16'h0002);
        outs();
        for (int a = 0; a < 6; a++) wr(3'(a), 16'h0000);
        outs();
        for (int i = 0; i < 18; i++) begin
            fire(18'h00001 << i, 10'h000);
            rchk(loc[i][6:4]);
            chk("request_pending", 16'h0001, {15'h0000, pend});
        end
        clr();
        rchk(3'h2);
        chk("request_pending", 16'h0000, {15'h0000, pend});
        // Peripheral set and software clear meet at the same edge
        @(posedge clk) fire_req <= 18'h00100;
        @(posedge clk) begin
            fire_req <= 18'h00000;
            reg_wr <= 1'b1;
            reg_addr <= 3'h2;
            reg_wdata <= 16'h0000;
        end
        @(posedge clk) reg_wr <= 1'b0;
        m[2] = 16'h0008;
        rchk(3'h2);
        repeat (6) begin
            r = rnd();
            fire(r[17:0] & r[31:14], 10'h000);
            for (int a = 2; a < 6; a++) rchk(3'(a));
            clr();
        end
        fire(18'h00000, 10'h3FF);
        rchk(3'h0);
        foreach (wmask[k]) if (k < 3) begin
            wr(3'h0, 16'h0400 >> k);
            fire(18'h00000, 10'h3C0);
            rchk(3'h0);
        end
        for (int i = 0; i < 10; i++) begin
            wr(3'h0, 16'h0700);
            fire(18'h00000, 10'h001 << i);
            rchk(3'h0);
        end
        for (int p = 0; p < 3; p++) for (int pol = 0; pol < 2; pol++) begin
            wr(3'h1, 16'(pol) << p);
            @(posedge clk) pin_lvl[p] <= pol[0];
            repeat (8) @(posedge clk);
            clr();
            @(posedge clk) pin_lvl[p] <= !pol[0];
            repeat (8) @(posedge clk);
            m[ploc[p][6:4]][ploc[p][3:0]] = 1'b1;
            rchk(ploc[p][6:4]);
            clr();
            @(posedge clk) pin_lvl[p] <= pol[0];
            repeat (8) @(posedge clk);
            rchk(ploc[p][6:4]);
        end
        @(posedge clk) hold_lvl <= 1'b1;
        repeat (6) @(posedge clk);
        m[1][14] = 1'b1;
        wr(3'h1, 16'h0000);
        rchk(3'h1);
        @(posedge clk) hold_lvl <= 1'b0;
        repeat (6) @(posedge clk);
        m[1][14] = 1'b0;
        rchk(3'h1);
        // With the clock enable low, neither a write nor a request may land
        keep = m[2];
        @(posedge clk) clk_en <= 1'b0;
        wr(3'h2, 16'h3FEF);
        fire(18'h20000, 10'h000);
        @(posedge clk) clk_en <= 1'b1;
        m[2] = keep;
        rchk(3'h2);
        final_report();
    end
endmodule // itfc_ctrl_bench
`default_nettype wire
